// File: design/ctu_defs.svh
// Purpose: constants of the clock tick unit
// Assumes: included by its bare name
// Notes: offsets are byte addresses on the bus, except CTU_CSR_IDX, a word index
`ifndef CTU_DEFS_SVH
`define CTU_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CTU_CSR_IDX 8'h26
`define CTU_STAT_ADDR 8'hA0
`define CTU_MASK_ADDR 8'hA4
`define CTU_CSR_RST 8'h00
`define CTU_EV_RST 2'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTU_FLAG_BIT 0
`define CTU_IE_BIT 1
`define CTU_SEL_LSB 2
`define CTU_EV_TICK 0
`define CTU_EV_WAKE 1

// ----------------------------------------
// Prescaler divisions per period code
// ----------------------------------------
`define CTU_CNT_W 18
`define CTU_DIV0 16000
`define CTU_DIV1 32000
`define CTU_DIV2 80000
`define CTU_DIV3 200000

`endif

// File: design/ctu_pkg.sv
// Purpose: types of the clock tick unit
// Assumes: ctu_defs.svh supplies the widths
// Notes: mode RUN must stay the first member
`include "ctu_defs.svh"

package ctu_pkg;

	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		CTU_RUN,
		CTU_WAIT,
		CTU_ACT_HALT,
		CTU_HALT
	} ctu_mode_t;

	// ----------------------------------------
	// Whole state of the unit
	// ----------------------------------------
	typedef struct packed {
		ctu_mode_t mode;
		logic [`CTU_CNT_W-1:0] cnt;
		logic [1:0] cur_sel;
		logic [1:0] period_select;
		logic tick_irq_enable;
		logic tick_flag;
		logic [1:0] ev_stat;
		logic [1:0] ev_mask;
		logic ack;
		logic [7:0] rdata;
	} ctu_state_t;

endpackage

// File: design/ctu_top.sv
// Purpose: clock tick unit, periodic tick flag and low-power mode control
// Assumes: core_clk stands for the divided oscillator clock
// Notes: classic Wishbone slave, one wait state on every access
//
// Functional notes
// - The tick period is 16000, 32000, 80000 or 200000 clocks by code.
// - A new period code takes effect only when the running period ends.
// - The tick interrupt asks only with enable set and no global mask.
// - Halt with the tick enable set enters halt-with-tick, else full halt.
// - The flag sets at period end and only a read of the register clears it.
// - In idle mode counting goes on and a tick interrupt ends idle.
// - In halt-with-tick counting goes on, register writes freeze, a tick sets the flag and, with no global mask, wakes.
// - In full halt counter and register freeze until an external wake.
// - The tick interrupt never wakes the unit from full halt.
// - Reset clears the register to zero; bits 7 to 4 always read zero.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "ctu_defs.svh"

module ctu_top #(
	parameter int unsigned DIV0 = `CTU_DIV0,
	parameter int unsigned DIV1 = `CTU_DIV1,
	parameter int unsigned DIV2 = `CTU_DIV2,
	parameter int unsigned DIV3 = `CTU_DIV3
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic halt_insn,
	input wire logic wait_insn,
	input wire logic global_mask,
	input wire logic ext_wake,
	output logic tick_irq,
	output logic irq,
	output ctu_pkg::ctu_mode_t power_mode
);
	import ctu_pkg::*;

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int CW = `CTU_CNT_W;
	localparam logic [CW-1:0] LIM0 = CW'(DIV0 - 1);
	localparam logic [CW-1:0] LIM1 = CW'(DIV1 - 1);
	localparam logic [CW-1:0] LIM2 = CW'(DIV2 - 1);
	localparam logic [CW-1:0] LIM3 = CW'(DIV3 - 1);
	localparam logic [7:0] CSR_ADDR = 8'(`CTU_CSR_IDX * 4);
	localparam logic [7:0] STAT_ADDR = `CTU_STAT_ADDR;
	localparam logic [7:0] MASK_ADDR = `CTU_MASK_ADDR;

	ctu_state_t st;
	ctu_state_t next_st;

	logic [CW-1:0] lim;
	logic counting;
	logic wrap;
	logic take;
	logic bus_live;
	logic hit_csr;
	logic hit_stat;
	logic hit_mask;
	logic rd_csr;
	logic wr_csr;
	logic wake_req;

	// ----------------------------------------
	// Decode and helper terms
	// ----------------------------------------
	// Limit follows the latched code, not the register
	always_comb begin
		unique case (st.cur_sel)
			2'd0: lim = LIM0;
			2'd1: lim = LIM1;
			2'd2: lim = LIM2;
			2'd3: lim = LIM3;
		endcase
	end

	// Only full halt stops the prescaler
	assign counting = (st.mode != CTU_HALT);
	assign wrap = counting && (st.cnt == lim);
	assign take = wb_cyc_i && wb_stb_i && !st.ack;
	// Control register writes and read-clear are frozen in both halt modes; status and mask stay live
	assign bus_live = (st.mode == CTU_RUN) || (st.mode == CTU_WAIT);
	assign hit_csr = (wb_adr_i[7:2] == CSR_ADDR[7:2]);
	assign hit_stat = (wb_adr_i[7:2] == STAT_ADDR[7:2]);
	assign hit_mask = (wb_adr_i[7:2] == MASK_ADDR[7:2]);
	assign rd_csr = take && !wb_we_i && hit_csr && bus_live;
	assign wr_csr = take && wb_we_i && hit_csr && bus_live && wb_sel_i[0];

	// Interrupt gated by enable and global mask
	assign tick_irq = st.tick_flag && st.tick_irq_enable && !global_mask;
	// Tick only wakes from idle or halt-with-tick
	assign wake_req = tick_irq || ext_wake;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.ack = take;

		// Prescaler with automatic restart
		if (counting) begin
			next_st.cnt = wrap ? '0 : st.cnt + 1'b1;
		end
		// Code latched at period boundary only
		if (wrap) begin
			next_st.cur_sel = st.period_select;
		end

		// Read data, unmapped words read zero
		if (take && !wb_we_i) begin
			if (hit_csr) begin
				next_st.rdata = {4'h0, st.period_select,
					st.tick_irq_enable, st.tick_flag};
			end else if (hit_stat) begin
				next_st.rdata = {6'h00, st.ev_stat};
			end else if (hit_mask) begin
				next_st.rdata = {6'h00, st.ev_mask};
			end else begin
				next_st.rdata = 8'h00;
			end
		end

		// Flag only cleared by a read; writes leave it alone
		if (rd_csr) begin
			next_st.tick_flag = 1'b0;
		end
		if (wr_csr) begin
			next_st.period_select =
				wb_dat_i[`CTU_SEL_LSB +: 2];
			next_st.tick_irq_enable = wb_dat_i[`CTU_IE_BIT];
		end
		// Status reads clear, mask is plain storage
		if (take && !wb_we_i && hit_stat) begin
			next_st.ev_stat = `CTU_EV_RST;
		end
		if (take && wb_we_i && hit_mask && wb_sel_i[0]) begin
			next_st.ev_mask = wb_dat_i[1:0];
		end

		// Set after clear, so a tick in a read cycle survives
		if (wrap) begin
			next_st.tick_flag = 1'b1;
			next_st.ev_stat[`CTU_EV_TICK] = 1'b1;
		end

		// Power mode sequencing
		unique case (st.mode)
			CTU_RUN: begin
				if (halt_insn) begin
					next_st.mode = st.tick_irq_enable ?
						CTU_ACT_HALT : CTU_HALT;
				end else if (wait_insn) begin
					next_st.mode = CTU_WAIT;
				end
			end
			CTU_WAIT: begin
				if (wake_req) begin
					next_st.mode = CTU_RUN;
				end
			end
			CTU_ACT_HALT: begin
				if (wake_req) begin
					next_st.mode = CTU_RUN;
					next_st.ev_stat[`CTU_EV_WAKE] = 1'b1;
				end
			end
			CTU_HALT: begin
				// Tick cannot fire here anyway, counter is stopped
				if (ext_wake) begin
					next_st.mode = CTU_RUN;
					next_st.ev_stat[`CTU_EV_WAKE] = 1'b1;
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Zero reset gives code 00, enable off, flag clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = st.ack;
	assign wb_dat_o = {24'h00_0000, st.rdata};
	assign irq = |(st.ev_stat & st.ev_mask);
	assign power_mode = st.mode;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	property p_wrap_flag;
		wrap |=> (st.cnt == '0) && st.tick_flag;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag)
		else $error("period end did not restart and flag");

	property p_lim_code;
		(st.cur_sel == 2'd0) |-> (lim == CW'(DIV0 - 1));
	endproperty
	a_lim_code: assert property (p_lim_code)
		else $error("code 00 limit wrong");

	property p_sel_hold;
		!wrap |=> $stable(st.cur_sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("period code changed mid period");

	property p_irq_gate;
		tick_irq |-> st.tick_irq_enable && !global_mask;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("tick interrupt without enable");

	property p_halt_enter;
		(st.mode == CTU_RUN && halt_insn) |=>
			(st.mode == ($past(st.tick_irq_enable) ?
			CTU_ACT_HALT : CTU_HALT));
	endproperty
	a_halt_enter: assert property (p_halt_enter)
		else $error("wrong halt mode entered");

	property p_read_clear;
		(rd_csr && !wrap) |=> !st.tick_flag ##1 wb_ack_o == 1'b0;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("register read did not clear flag");

	property p_write_keeps_flag;
		(take && wb_we_i && st.tick_flag) |=> st.tick_flag;
	endproperty
	a_write_keeps_flag: assert property (p_write_keeps_flag)
		else $error("write cleared the flag");

	property p_wait_count;
		(st.mode == CTU_WAIT && !wrap) |=>
			st.cnt == $past(st.cnt) + 1'b1;
	endproperty
	a_wait_count: assert property (p_wait_count)
		else $error("counter stalled in idle");

	property p_ah_frozen;
		(st.mode == CTU_ACT_HALT) |=>
			$stable(st.period_select) && $stable(st.tick_irq_enable);
	endproperty
	a_ah_frozen: assert property (p_ah_frozen)
		else $error("register changed in halt-with-tick");

	property p_halt_frozen;
		(st.mode == CTU_HALT) |=>
			$stable(st.cnt) && $stable(st.tick_flag);
	endproperty
	a_halt_frozen: assert property (p_halt_frozen)
		else $error("counter moved in full halt");

	property p_no_tick_wake;
		(st.mode == CTU_HALT && !ext_wake) |=> st.mode == CTU_HALT;
	endproperty
	a_no_tick_wake: assert property (p_no_tick_wake)
		else $error("left full halt without external wake");

	property p_rsvd_zero;
		(take && !wb_we_i && hit_csr) |=> wb_dat_o[7:4] == 4'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");

	// The prescaler itself is the cycle counter: it never passes its limit
	property p_restart;
		counting |-> (st.cnt <= lim);
	endproperty
	a_restart: assert property (p_restart)
		else $error("prescaler ran past its period limit");

	// ----------------------------------------
	// Covers
	// ----------------------------------------
	c_wrap_read: cover property (wrap && rd_csr);
	c_ah_wake: cover property (st.mode == CTU_ACT_HALT ##1
		st.mode == CTU_RUN);
	c_halt_wake: cover property (st.mode == CTU_HALT && ext_wake);
	c_sel_change: cover property (wrap &&
		st.period_select != st.cur_sel);

endmodule // ctu_top

// File: sim/testbench.sv
// Purpose: self-checking bench for the clock tick unit
// Assumes: shortened periods 40/60/100/140 clocks
// Notes: periods measured between irq rises, status read in between
`timescale 1ns/100ps

module testbench;
	import ctu_pkg::*;

	// ----------------------------------------
	// Clock, stimulus and counters
	// ----------------------------------------
	localparam int D[4] = '{40, 60, 100, 140};
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic halt_insn = 1'b0;
	logic wait_insn = 1'b0;
	logic global_mask = 1'b0;
	logic ext_wake = 1'b0;
	logic tick_irq;
	logic irq;
	ctu_mode_t power_mode;
	int error_cnt = 0;
	int checked = 0;
	int cyc_n = 0;
	int s0, s1, s2, prev;
	logic [31:0] r;

	// 250 MHz clock and a free cycle stamp
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) cyc_n <= cyc_n + 1;

	ctu_top #(.DIV0(D[0]), .DIV1(D[1]), .DIV2(D[2]), .DIV3(D[3])) u_dut (
		.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .halt_insn(halt_insn), .wait_insn(wait_insn),
		.global_mask(global_mask), .ext_wake(ext_wake),
		.tick_irq(tick_irq), .irq(irq), .power_mode(power_mode)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Classic cycle; request held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h00_0000, d};
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// Stamp the next irq rise, then clear status; irq lags by a cycle
	task automatic tick(output int t);
		while (irq !== 1'b1) begin
			@(posedge core_clk);
		end
		t = cyc_n;
		bus(1'b0, 8'hA0, 8'h00, r);
		repeat (2) @(posedge core_clk);
	endtask

	// One-cycle pulse on {ext_wake, wait_insn, halt_insn}
	task automatic pulse(input logic [2:0] p);
		@(posedge core_clk);
		{ext_wake, wait_insn, halt_insn} <= p;
		@(posedge core_clk);
		{ext_wake, wait_insn, halt_insn} <= 3'h0;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic to_run;
		while (power_mode !== CTU_RUN) begin
			@(posedge core_clk);
		end
	endtask

	task automatic results;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		bus(1'b0, 8'h98, 8'h00, r);
		chk("csr_reset", 32'h0000_0000, r);
		bus(1'b1, 8'h98, 8'hF3, r);
		bus(1'b0, 8'h98, 8'h00, r);
		chk("csr_rsvd", 32'h0000_0002, r);
		bus(1'b0, 8'h40, 8'h00, r);
		chk("unmapped", 32'h0000_0000, r);
		bus(1'b1, 8'hA4, 8'h01, r);
		tick(s0);
		prev = D[0];
		// Code change lands mid-period; old period must finish first
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h98, 8'(k * 4 + 2), r);
			tick(s1);
			tick(s2);
			chk("period_old", 32'(prev), 32'(s1 - s0));
			chk("period_new", 32'(D[k]), 32'(s2 - s1));
			prev = D[k];
			s0 = s2;
		end
		chk("tick_irq_on", 32'h0000_0001, 32'(tick_irq));
		global_mask <= 1'b1;
		@(posedge core_clk);
		chk("tick_irq_gm", 32'h0000_0000, 32'(tick_irq));
		global_mask <= 1'b0;
		bus(1'b0, 8'h98, 8'h00, r);
		chk("flag_set", 32'h0000_000F, r);
		bus(1'b0, 8'h98, 8'h00, r);
		chk("flag_clr", 32'h0000_000E, r);
		bus(1'b1, 8'h98, 8'h02, r);
		pulse(3'h2);
		chk("mode_wait", 32'(CTU_WAIT), 32'(power_mode));
		to_run();
		chk("wake_wait", 32'(CTU_RUN), 32'(power_mode));
		bus(1'b0, 8'h98, 8'h00, r);
		pulse(3'h1);
		chk("mode_act", 32'(CTU_ACT_HALT), 32'(power_mode));
		to_run();
		chk("wake_act", 32'(CTU_RUN), 32'(power_mode));
		bus(1'b1, 8'h98, 8'h00, r);
		bus(1'b0, 8'h98, 8'h00, r);
		pulse(3'h1);
		chk("mode_halt", 32'(CTU_HALT), 32'(power_mode));
		bus(1'b1, 8'h98, 8'h0C, r);
		repeat (300) @(posedge core_clk);
		bus(1'b0, 8'h98, 8'h00, r);
		chk("halt_frozen", 32'h0000_0000, r);
		chk("halt_stays", 32'(CTU_HALT), 32'(power_mode));
		pulse(3'h4);
		chk("wake_ext", 32'(CTU_RUN), 32'(power_mode));
		bus(1'b0, 8'hA0, 8'h00, r);
		chk("ev_wake", 32'h0000_0002, r & 32'h0000_0002);
		// Masked event stays pending in status without irq
		bus(1'b1, 8'hA4, 8'h00, r);
		repeat (300) @(posedge core_clk);
		chk("irq_masked", 32'h0000_0000, 32'(irq));
		bus(1'b1, 8'hA4, 8'h01, r);
		repeat (2) @(posedge core_clk);
		chk("irq_unmask", 32'h0000_0001, 32'(irq));
		// Second tick aligns the clear right after a fresh period end
		tick(s0);
		tick(s1);
		chk("irq_clear", 32'h0000_0000, 32'(irq));
		results();
	end

	// Guard against a hung handshake or mode
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		results();
	end
endmodule // testbench
